//--- core/aocr_defs.svh
`ifndef AOCR_DEFS_SVH
`define AOCR_DEFS_SVH

// Register offsets
`define AOCR_OFS_OUTPUT_STATE   8'h0C
`define AOCR_OFS_LOW_PAIR       8'h0D
`define AOCR_OFS_MISC_TIMING    8'h10
`define AOCR_OFS_THERMAL        8'h13

// Reset values
`define AOCR_RST_OUTPUT_STATE   8'h1F
`define AOCR_RST_LOW_PAIR       8'h00
`define AOCR_RST_MISC_TIMING    8'h01

// Output state control fields
`define AOCR_BIT_MUTE_ALL       4
`define AOCR_BIT_OFS_NOSHUT     5
`define AOCR_BIT_DEV_RESET      7

// Low state and pairing fields
`define AOCR_BIT_PAIR_12        4
`define AOCR_BIT_PAIR_34        5

// Misc timing fields
`define AOCR_LSB_THRESHOLD      0
`define AOCR_BIT_XTALK          2
`define AOCR_BIT_DIAG_PAUSE     3
`define AOCR_BIT_DIAG_SLOW      4
`define AOCR_BIT_RAMP_SLOW      5
`define AOCR_BIT_RAMP_DOWN_SLOW 7

// Timing
`define AOCR_CLK_PERIOD_PS      64'd5000
`define AOCR_DIAG_PAUSE_MS      64'd20
`define AOCR_DIAG_PAUSE_CYC     ((`AOCR_DIAG_PAUSE_MS * 64'd1000000000) / `AOCR_CLK_PERIOD_PS)
`define AOCR_DIAG_PHASE_CYC     64'd1000
`define AOCR_DIAG_SLOW_FACTOR   4

`endif

//--- core/aocr_pkg.sv
package aocr_pkg;

    typedef enum logic [1:0] {
        AOCR_CH_HIZ     = 2'b00,
        AOCR_CH_MUTE    = 2'b01,
        AOCR_CH_PLAY    = 2'b10,
        AOCR_CH_LOWLOW  = 2'b11
    } aocr_ch_mode_type;

    typedef enum logic [3:0] {
        AOCR_I2C_IDLE   = 4'b0000,
        AOCR_I2C_ADDR   = 4'b0001,
        AOCR_I2C_AACK   = 4'b0010,
        AOCR_I2C_PTR    = 4'b0011,
        AOCR_I2C_PACK   = 4'b0100,
        AOCR_I2C_WR     = 4'b0101,
        AOCR_I2C_WACK   = 4'b0110,
        AOCR_I2C_RD     = 4'b0111,
        AOCR_I2C_RACK   = 4'b1000
    } aocr_i2c_state_type;

    typedef enum logic [2:0] {
        AOCR_DG_IDLE    = 3'b000,
        AOCR_DG_SUPPLY  = 3'b001,
        AOCR_DG_PAUSE   = 3'b010,
        AOCR_DG_GROUND  = 3'b011,
        AOCR_DG_DONE    = 3'b100
    } aocr_diag_state_type;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } aocr_wr_type;

    typedef struct packed {
        logic       pair_12;
        logic       pair_34;
        logic       crosstalk_on;
        logic       ramp_slow;
        logic       ramp_down_slow;
        logic [1:0] offset_threshold;
        logic       offset_noshut;
    } aocr_ctrl_type;

endpackage

//--- core/aocr_top.sv
// Function
// - Bits 0..3 of output control: set holds channel high impedance, clear mutes driven.
// - Clearing bit 4 moves every channel that is neither high impedance nor low-low from mute to play.
// - Output control resets to all channels high impedance, muted, offset detect on.
// - Bit 5 stops offset faults shutting channels down; fault still reported.
// - Second output control bits 0..3 force matching channel into low-low state.
// - Bit 4 of second output control pairs channels one and two.
// - Bit 5 of second output control pairs channels three and four.
// - Second output control resets to zero: no low-low, no pairing.
// - Misc bits 1:0 select offset threshold: 0.8 V, 1.6 V default, 2.4 V.
// - Misc bit 2 enables crosstalk enhancement; misc register resets to 0x01.
// - Misc bit 3 inserts a 20 ms pause between load diagnostic phases.
// - Misc bit 4 makes supply and ground short checks last four times longer.
// - Misc bit 5 makes the common voltage ramp three times longer.
// - Misc bit 7 selects slower common voltage ramp-down when leaving mute.
// - Thermal status bits 0..3 read one while channels are in foldback.
// - Thermal status bits 4..7 read one while channels are in overtemperature shutdown.
// - Thermal status reads all zeros by default.
`timescale 1ns/1ps
`include "aocr_defs.svh"

module aocr_top #(
    parameter logic [6:0]  TARGET_ADDR     = 7'h2A,
    parameter logic [31:0] DIAG_PAUSE_CYC  = 32'(`AOCR_DIAG_PAUSE_CYC),
    parameter logic [31:0] DIAG_PHASE_CYC  = 32'(`AOCR_DIAG_PHASE_CYC)
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    input  wire logic [3:0]                  foldback_in,
    input  wire logic [3:0]                  overtemp_in,
    input  wire logic [3:0]                  offset_fault_in,
    input  wire logic                        diag_start,
    output aocr_pkg::aocr_ch_mode_type [3:0] ch_mode,
    output logic [3:0]                       offset_fault_report,
    output aocr_pkg::aocr_ctrl_type          ctrl,
    output logic                             short_to_supply_check,
    output logic                             short_to_ground_check,
    output logic                             load_diagnostic_busy
);

    // Two-flop synchronisers for the I2C, foldback, overtemp and offset fault pins; diag_start is not synchronised
    logic [13:0] sync_a;
    logic [13:0] sync_b;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 14'h0003;
            sync_b <= 14'h0003;
        end else begin
            sync_a <= {offset_fault_in, overtemp_in, foldback_in, sda_in, scl_in};
            sync_b <= sync_a;
        end
    end
    wire       scl_s     = sync_b[0];
    wire       sda_s     = sync_b[1];
    wire [3:0] foldback  = sync_b[5:2];
    wire [3:0] overtemp  = sync_b[9:6];
    wire [3:0] ofs_fault = sync_b[13:10];
    logic scl_d;
    logic sda_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
    wire i2c_stop  = scl_s & scl_d & ~sda_d & sda_s;
    // Registers
    logic [7:0] output_state_control;
    logic [7:0] low_state_and_pairing;
    logic [7:0] misc_timing_select;
    logic [7:0] thermal_state_flags;
    aocr_pkg::aocr_wr_type wr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_state_flags <= 8'h00;
        end else begin
            thermal_state_flags <= {overtemp, foldback};
        end
    end

    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] r0c,
                                            input logic [7:0] r0d,
                                            input logic [7:0] r10,
                                            input logic [7:0] r13);
        case (a)
            `AOCR_OFS_OUTPUT_STATE: reg_read = {1'b0, r0c[6:0]};
            `AOCR_OFS_LOW_PAIR:     reg_read = r0d;
            `AOCR_OFS_MISC_TIMING:  reg_read = r10;
            `AOCR_OFS_THERMAL:      reg_read = r13;
            default:                reg_read = 8'h00;
        endcase
    endfunction
    function automatic logic hit(input aocr_pkg::aocr_wr_type w, input logic [7:0] a);
        hit = w.en && (w.addr == a);
    endfunction
    wire soft_reset = hit(wr, `AOCR_OFS_OUTPUT_STATE) && wr.data[`AOCR_BIT_DEV_RESET];

    // writes only arrive through the I2C target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_state_control  <= `AOCR_RST_OUTPUT_STATE;
            low_state_and_pairing <= `AOCR_RST_LOW_PAIR;
            misc_timing_select    <= `AOCR_RST_MISC_TIMING;
        end else if (soft_reset) begin
            output_state_control  <= `AOCR_RST_OUTPUT_STATE;
            low_state_and_pairing <= `AOCR_RST_LOW_PAIR;
            misc_timing_select    <= `AOCR_RST_MISC_TIMING;
        end else begin
            if (hit(wr, `AOCR_OFS_OUTPUT_STATE)) begin
                output_state_control <= {1'b0, wr.data[6:0]};
            end
            if (hit(wr, `AOCR_OFS_LOW_PAIR)) begin
                low_state_and_pairing <= wr.data;
            end
            if (hit(wr, `AOCR_OFS_MISC_TIMING)) begin
                misc_timing_select <= wr.data;
            end
        end
    end

    // I2C target
    aocr_pkg::aocr_i2c_state_type state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       rw;
    logic       nacked;

    wire [7:0] ptr_inc = ptr + 8'h01;
    wire [7:0] rd_now  = reg_read(ptr, output_state_control, low_state_and_pairing,
                                  misc_timing_select, thermal_state_flags);
    wire [7:0] rd_next = reg_read(ptr_inc, output_state_control, low_state_and_pairing,
                                  misc_timing_select, thermal_state_flags);
    wire rx_state  = (state == aocr_pkg::AOCR_I2C_ADDR) || (state == aocr_pkg::AOCR_I2C_PTR)
                     || (state == aocr_pkg::AOCR_I2C_WR);
    wire byte_done = (bitcnt == 4'd8);
    assign sda_out = 1'b0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state  <= aocr_pkg::AOCR_I2C_IDLE;
            bitcnt <= 4'd0;
            shreg  <= 8'h00;
            ptr    <= 8'h00;
            rw     <= 1'b0;
            nacked <= 1'b0;
            sda_oe <= 1'b0;
            wr     <= '0;
        end else begin
            wr.en <= 1'b0;
            if (i2c_start) begin
                state  <= aocr_pkg::AOCR_I2C_ADDR;
                bitcnt <= 4'd0;
                sda_oe <= 1'b0;
            end else if (i2c_stop) begin
                state  <= aocr_pkg::AOCR_I2C_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (rx_state && !byte_done) begin
                    shreg  <= {shreg[6:0], sda_s};
                    bitcnt <= bitcnt + 4'd1;
                end
                if (state == aocr_pkg::AOCR_I2C_RACK) begin
                    nacked <= sda_s;
                end
            end else if (scl_fall) begin
                case (state)
                    aocr_pkg::AOCR_I2C_ADDR: begin
                        if (byte_done) begin
                            if (shreg[7:1] == TARGET_ADDR) begin
                                rw     <= shreg[0];
                                sda_oe <= 1'b1;
                                state  <= aocr_pkg::AOCR_I2C_AACK;
                            end else begin
                                state <= aocr_pkg::AOCR_I2C_IDLE;
                            end
                        end
                    end
                    aocr_pkg::AOCR_I2C_AACK: begin
                        bitcnt <= 4'd0;
                        if (rw) begin
                            shreg  <= rd_now;
                            sda_oe <= ~rd_now[7];
                            state  <= aocr_pkg::AOCR_I2C_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= aocr_pkg::AOCR_I2C_PTR;
                        end
                    end
                    aocr_pkg::AOCR_I2C_PTR: begin
                        if (byte_done) begin
                            ptr    <= shreg;
                            sda_oe <= 1'b1;
                            state  <= aocr_pkg::AOCR_I2C_PACK;
                        end
                    end
                    aocr_pkg::AOCR_I2C_WR: begin
                        if (byte_done) begin
                            wr     <= '{en: 1'b1, addr: ptr, data: shreg};
                            ptr    <= ptr_inc;
                            sda_oe <= 1'b1;
                            state  <= aocr_pkg::AOCR_I2C_WACK;
                        end
                    end
                    aocr_pkg::AOCR_I2C_PACK,
                    aocr_pkg::AOCR_I2C_WACK: begin
                        bitcnt <= 4'd0;
                        sda_oe <= 1'b0;
                        state  <= aocr_pkg::AOCR_I2C_WR;
                    end
                    aocr_pkg::AOCR_I2C_RD: begin
                        if (bitcnt == 4'd7) begin
                            sda_oe <= 1'b0;
                            state  <= aocr_pkg::AOCR_I2C_RACK;
                        end else begin
                            shreg  <= {shreg[6:0], 1'b0};
                            sda_oe <= ~shreg[6];
                            bitcnt <= bitcnt + 4'd1;
                        end
                    end
                    aocr_pkg::AOCR_I2C_RACK: begin
                        // Controller NACK ends the read; wait for stop
                        if (nacked) begin
                            state <= aocr_pkg::AOCR_I2C_IDLE;
                        end else begin
                            ptr    <= ptr_inc;
                            shreg  <= rd_next;
                            sda_oe <= ~rd_next[7];
                            bitcnt <= 4'd0;
                            state  <= aocr_pkg::AOCR_I2C_RD;
                        end
                    end
                    default: begin
                        state <= aocr_pkg::AOCR_I2C_IDLE;
                    end
                endcase
            end
        end
    end
    // Channel output state
    wire       mute_all = output_state_control[`AOCR_BIT_MUTE_ALL];
    wire       noshut   = output_state_control[`AOCR_BIT_OFS_NOSHUT];

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
            wire hiz_bit  = output_state_control[ch];
            wire low_bit  = low_state_and_pairing[ch];
            wire ofs_shut = ofs_fault[ch] & ~noshut;
            aocr_pkg::aocr_ch_mode_type next_mode;
            // Low-low wins so a forced safe state is never overridden
            // low-low force
            assign next_mode = low_bit  ? aocr_pkg::AOCR_CH_LOWLOW :
                               (hiz_bit || ofs_shut) ? aocr_pkg::AOCR_CH_HIZ :
                               mute_all ? aocr_pkg::AOCR_CH_MUTE : aocr_pkg::AOCR_CH_PLAY;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ch_mode[ch] <= aocr_pkg::AOCR_CH_HIZ;
                end else begin
                    ch_mode[ch] <= next_mode;
                end
            end
        end
    endgenerate
    // Control outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl                <= '0;
            offset_fault_report <= 4'h0;
        end else begin
            offset_fault_report    <= ofs_fault;
            ctrl.pair_12           <= low_state_and_pairing[`AOCR_BIT_PAIR_12];
            ctrl.pair_34           <= low_state_and_pairing[`AOCR_BIT_PAIR_34];
            ctrl.crosstalk_on      <= misc_timing_select[`AOCR_BIT_XTALK];
            ctrl.ramp_slow         <= misc_timing_select[`AOCR_BIT_RAMP_SLOW];
            ctrl.ramp_down_slow    <= misc_timing_select[`AOCR_BIT_RAMP_DOWN_SLOW];
            ctrl.offset_threshold  <= misc_timing_select[`AOCR_LSB_THRESHOLD +: 2];
            ctrl.offset_noshut     <= noshut;
        end
    end

    // Load diagnostic phase sequencer
    aocr_pkg::aocr_diag_state_type dg_state;
    logic [31:0] dg_cnt;
    wire [31:0] phase_len = misc_timing_select[`AOCR_BIT_DIAG_SLOW]
                            ? DIAG_PHASE_CYC * `AOCR_DIAG_SLOW_FACTOR : DIAG_PHASE_CYC;
    wire        pause_on  = misc_timing_select[`AOCR_BIT_DIAG_PAUSE];
    wire        dg_last   = (dg_cnt <= 32'd1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dg_state <= aocr_pkg::AOCR_DG_IDLE;
            dg_cnt   <= 32'd0;
        end else begin
            if (!dg_last) begin
                dg_cnt <= dg_cnt - 32'd1;
            end
            case (dg_state)
                aocr_pkg::AOCR_DG_IDLE: begin
                    if (diag_start) begin
                        dg_cnt   <= phase_len;
                        dg_state <= aocr_pkg::AOCR_DG_SUPPLY;
                    end
                end
                aocr_pkg::AOCR_DG_SUPPLY: begin
                    if (dg_last) begin
                        dg_cnt   <= pause_on ? DIAG_PAUSE_CYC : phase_len;
                        dg_state <= pause_on ? aocr_pkg::AOCR_DG_PAUSE : aocr_pkg::AOCR_DG_GROUND;
                    end
                end
                aocr_pkg::AOCR_DG_PAUSE: begin
                    if (dg_last) begin
                        dg_cnt   <= phase_len;
                        dg_state <= aocr_pkg::AOCR_DG_GROUND;
                    end
                end
                aocr_pkg::AOCR_DG_GROUND: begin
                    if (dg_last) begin
                        dg_state <= aocr_pkg::AOCR_DG_DONE;
                    end
                end
                aocr_pkg::AOCR_DG_DONE: begin
                    dg_state <= aocr_pkg::AOCR_DG_IDLE;
                end
                default: begin
                    dg_state <= aocr_pkg::AOCR_DG_IDLE;
                end
            endcase
        end
    end

    assign short_to_supply_check = (dg_state == aocr_pkg::AOCR_DG_SUPPLY);
    assign short_to_ground_check = (dg_state == aocr_pkg::AOCR_DG_GROUND);
    assign load_diagnostic_busy  = (dg_state != aocr_pkg::AOCR_DG_IDLE);

endmodule

//--- bench/aocr_top_asserts.sv
`timescale 1ns/1ps
module aocr_top_checker #(
    parameter logic [31:0] DIAG_PAUSE_CYC = 32'h0000_0032,
    parameter logic [31:0] DIAG_PHASE_CYC = 32'h0000_0014
) (
    input wire logic                             clk,
    input wire logic                             rst_n,
    input wire logic                             scl_in,
    input wire logic                             sda_oe,
    input wire logic                             diag_start,
    input wire logic [3:0]                       offset_fault_in,
    input wire logic [3:0]                       offset_fault_report,
    input wire aocr_pkg::aocr_ch_mode_type [3:0] ch_mode,
    input wire aocr_pkg::aocr_ctrl_type          ctrl,
    input wire logic                             short_to_supply_check,
    input wire logic                             short_to_ground_check,
    input wire logic                             load_diagnostic_busy
);
    logic [31:0] sup_len;
    logic [31:0] gnd_len;
    logic [31:0] gap_len;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Phase lengths counted here, too long for repetition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_len <= '0;
            gnd_len <= '0;
            gap_len <= '0;
        end else begin
            sup_len <= short_to_supply_check ? sup_len + 32'd1 : '0;
            gnd_len <= short_to_ground_check ? gnd_len + 32'd1 : '0;
            gap_len <= (short_to_supply_check || !load_diagnostic_busy) ? '0 : gap_len + 32'd1;
        end
    end
    sequence s_go;
        diag_start && !load_diagnostic_busy;
    endsequence
    sequence s_supply_on;
        short_to_supply_check && load_diagnostic_busy;
    endsequence
    property p_diag_start;
        s_go |=> s_supply_on;
    endproperty
    a_diag_start: assert property (p_diag_start)
        else $error("diag start did not enter supply phase");
    property p_sup_len;
        $fell(short_to_supply_check) |-> sup_len == DIAG_PHASE_CYC || sup_len == 4 * DIAG_PHASE_CYC;
    endproperty
    a_sup_len: assert property (p_sup_len)
        else $error("supply phase length wrong");
    property p_gnd_len;
        $fell(short_to_ground_check) |-> gnd_len == DIAG_PHASE_CYC || gnd_len == 4 * DIAG_PHASE_CYC;
    endproperty
    a_gnd_len: assert property (p_gnd_len)
        else $error("ground phase length wrong");
    property p_gap;
        $rose(short_to_ground_check) |-> gap_len == 0 || gap_len == DIAG_PAUSE_CYC;
    endproperty
    a_gap: assert property (p_gap)
        else $error("pause between phases wrong");
    property p_diag_excl;
        (short_to_supply_check || short_to_ground_check)
            |-> load_diagnostic_busy && !(short_to_supply_check && short_to_ground_check);
    endproperty
    a_diag_excl: assert property (p_diag_excl)
        else $error("diag phases overlap or not busy");
    property p_rst_ctrl;
        $rose(rst_n) |=> ctrl == 8'h02;
    endproperty
    a_rst_ctrl: assert property (p_rst_ctrl)
        else $error("ctrl not at defaults after reset");
    property p_rst_mode;
        $rose(rst_n) |=> ch_mode == 8'h00;
    endproperty
    a_rst_mode: assert property (p_rst_mode)
        else $error("channels not hiz after reset");
    property p_off_follow;
        $stable(offset_fault_in) [*6] |-> offset_fault_report == offset_fault_in;
    endproperty
    a_off_follow: assert property (p_off_follow)
        else $error("offset fault not reported");
    property p_off_shut(int ch);
        (!ctrl.offset_noshut && offset_fault_report[ch]) [*3]
            |-> ch_mode[ch] inside {aocr_pkg::AOCR_CH_HIZ, aocr_pkg::AOCR_CH_LOWLOW};
    endproperty
    for (genvar i = 0; i < 4; i++) begin : g_ch
        a_off_shut: assert property (p_off_shut(i))
            else $error("offset fault did not shut channel");
    end
    property p_sda_hold;
        scl_in [*4] |-> $stable(sda_oe);
    endproperty
    a_sda_hold: assert property (p_sda_hold)
        else $error("sda changed while scl high");
endmodule
bind aocr_top aocr_top_checker #(
    .DIAG_PAUSE_CYC(DIAG_PAUSE_CYC),
    .DIAG_PHASE_CYC(DIAG_PHASE_CYC)
) i_chk (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_oe(sda_oe),
    .diag_start(diag_start),
    .offset_fault_in(offset_fault_in),
    .offset_fault_report(offset_fault_report),
    .ch_mode(ch_mode),
    .ctrl(ctrl),
    .short_to_supply_check(short_to_supply_check),
    .short_to_ground_check(short_to_ground_check),
    .load_diagnostic_busy(load_diagnostic_busy)
);

//--- bench/aocr_i2c_host.sv
`timescale 1ns/1ps
module aocr_i2c_host #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input  wire logic clk,
    input  wire logic dut_pull,
    output logic      scl,
    output logic      sda
);
    logic drv_low = 1'b0;
    int   nack_count = 0;
    initial scl = 1'b1;
    // Pull-up: released line reads high
    assign sda = !(drv_low || dut_pull);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data moves two cycles after scl falls, never near a high phase
    task automatic put(input logic b);
        drv_low <= !b;
        tick(10);
        scl <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic get(output logic b);
        drv_low <= 1'b0;
        tick(10);
        scl <= 1'b1;
        tick(5);
        @(negedge clk);
        b = sda;
        tick(5);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic start;
        drv_low <= 1'b0;
        tick(10);
        scl <= 1'b1;
        tick(10);
        drv_low <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop;
        drv_low <= 1'b1;
        tick(10);
        scl <= 1'b1;
        tick(10);
        drv_low <= 1'b0;
        tick(10);
    endtask
    task automatic send(input logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(b);
        if (b) nack_count++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start;
        send({ADDR, 1'b0});
        send(a);
        send(d);
        stop;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic b;
        start;
        send({ADDR, 1'b0});
        send(a);
        start;
        send({ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            get(b);
            d[i] = b;
        end
        put(1'b1);
        stop;
    endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] PAUSE = 32'h0000_0032;
    localparam logic [31:0] PHASE = 32'h0000_0014;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic diag_start = 1'b0;
    logic [3:0] fold = 4'h0;
    logic [3:0] otemp = 4'h0;
    logic [3:0] offs = 4'h0;
    logic scl, sda, sda_out, sda_oe, sup, gnd, busy;
    logic [3:0] report;
    aocr_pkg::aocr_ch_mode_type [3:0] ch_mode;
    aocr_pkg::aocr_ctrl_type ctrl;
    int fail_count = 0;
    int tests_run = 0;
    always #2.5 clk = ~clk;
    aocr_top #(.TARGET_ADDR(7'h2A), .DIAG_PAUSE_CYC(PAUSE), .DIAG_PHASE_CYC(PHASE)) i_dut (
        .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .foldback_in(fold), .overtemp_in(otemp), .offset_fault_in(offs),
        .diag_start(diag_start), .ch_mode(ch_mode), .offset_fault_report(report), .ctrl(ctrl),
        .short_to_supply_check(sup), .short_to_ground_check(gnd), .load_diagnostic_busy(busy));
    aocr_i2c_host #(.ADDR(7'h2A)) i_host (.clk(clk), .dut_pull(sda_oe), .scl(scl), .sda(sda));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        check(d, exp);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_reset;
        rchk(8'h0C, 8'h1F);
        rchk(8'h0D, 8'h00);
        rchk(8'h10, 8'h01);
        rchk(8'h13, 8'h00);
        check(ctrl, 8'h02);
        check(ch_mode, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_modes;
        i_host.wr(8'h0C, 8'h1C);
        check(ch_mode, 8'h05);
        i_host.wr(8'h0C, 8'h0C);
        check(ch_mode, 8'h0A);
        i_host.wr(8'h0C, 8'h00);
        i_host.wr(8'h0D, 8'h33);
        check(ch_mode, 8'hAF);
        check(ctrl, 8'hC2);
        rchk(8'h0D, 8'h33);
        i_host.wr(8'h0D, 8'h00);
        check(ch_mode, 8'hAA);
        $display("mode test done");
    endtask
    task automatic t_misc;
        for (int c = 0; c < 3; c++) begin
            i_host.wr(8'h10, 8'hA4 | 8'(c));
            check(ctrl, {5'b00111, 2'(c), 1'b0});
            rchk(8'h10, 8'hA4 | 8'(c));
        end
        $display("misc test done");
    endtask
    task automatic t_diag;
        int ns, ng, gap, n;
        for (int k = 0; k < 2; k++) begin
            i_host.wr(8'h10, (k == 0) ? 8'h19 : 8'h01);
            ns = 0;
            ng = 0;
            gap = 0;
            n = 0;
            diag_start <= 1'b1;
            @(posedge clk);
            diag_start <= 1'b0;
            @(negedge clk);
            while ((busy || ns == 0) && n < 1000) begin
                if (sup) ns++;
                else if (gnd) ng++;
                else if (ns > 0 && ng == 0) gap++;
                n++;
                @(negedge clk);
            end
            if (n == 1000) begin
                fail_count++;
                $display("CHECK FAILED at %0t: diagnostic never finished", $time);
                tally_and_finish;
            end
            check(8'(ns), 8'((k == 0) ? 4 * PHASE : PHASE));
            check(8'(gap), 8'((k == 0) ? PAUSE : 0));
            check(8'(ng), 8'((k == 0) ? 4 * PHASE : PHASE));
        end
        $display("diagnostic test done");
    endtask
    task automatic t_status;
        fold <= 4'h5;
        otemp <= 4'hA;
        repeat (5) @(posedge clk);
        rchk(8'h13, 8'hA5);
        i_host.wr(8'h13, 8'h00);
        rchk(8'h13, 8'hA5);
        fold <= 4'h0;
        otemp <= 4'h0;
        i_host.wr(8'h0C, 8'h00);
        offs <= 4'h1;
        repeat (6) @(posedge clk);
        check({4'h0, report}, 8'h01);
        check(ch_mode, 8'hA8);
        i_host.wr(8'h0C, 8'h20);
        check(ch_mode, 8'hAA);
        check({4'h0, report}, 8'h01);
        offs <= 4'h0;
        $display("status test done");
    endtask
    task automatic t_soft;
        i_host.wr(8'h0D, 8'h3F);
        i_host.wr(8'h10, 8'hBF);
        i_host.wr(8'h0C, 8'h80);
        rchk(8'h0C, 8'h1F);
        rchk(8'h0D, 8'h00);
        rchk(8'h10, 8'h01);
        check(ch_mode, 8'h00);
        check(8'(i_host.nack_count), 8'h00);
        check({7'h00, sda_out}, 8'h00);
        $display("soft reset test done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset;
        t_modes;
        t_misc;
        t_diag;
        t_status;
        t_soft;
        tally_and_finish;
    end
endmodule
